// file: rtl/tlip_top.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tlip_top (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire tlip_pkg::tlip_req_s  src_req,
	input  wire tlip_pkg::tlip_src_t  handler_enter,
	input  wire tlip_pkg::tlip_src_t  handler_exit,
	output tlip_pkg::tlip_src_t       pending_state,
	output tlip_pkg::tlip_src_t       active_state,
	output logic                      irq
);

	logic                wr_en;
	tlip_pkg::tlip_wr_s  wr;
	logic                wr_hit;
	logic [31:0]         rd_data;
	logic                rd_hit;
	logic [31:0]         lane_mask;
	tlip_pkg::tlip_src_t req_vec;
	tlip_pkg::tlip_src_t set_vec;
	tlip_pkg::tlip_src_t clr_vec;
	tlip_pkg::tlip_src_t pend_vec;
	tlip_pkg::tlip_src_t act_vec;
	tlip_pkg::tlip_src_t rise_vec;
	tlip_pkg::tlip_src_t status_r, status_nxt;
	tlip_pkg::tlip_src_t mask_r, mask_nxt;
	tlip_pkg::tlip_src_t st_clr_vec;
	logic                irq_r, irq_nxt;
	logic                ar_take;

	////////////////////////////////////////////////////////////////////////
	// bus slave
	tlip_axil_slave u_bus (
		.clk           (clk),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr            (wr),
		.wr_hit        (wr_hit),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	assign ar_take = s_axi_arvalid && s_axi_arready;

	////////////////////////////////////////////////////////////////////////
	// source placement
	always_comb begin
		req_vec = tlip_pkg::RST_SRC_VEC;
		req_vec[tlip_pkg::BIT_DEBUG]       = src_req.debug_source;
		req_vec[tlip_pkg::BIT_EXT_A]       = src_req.ext_pin_source_a;
		req_vec[tlip_pkg::BIT_EXT_B]       = src_req.ext_pin_source_b;
		req_vec[tlip_pkg::BIT_EXT_C]       = src_req.ext_pin_source_c;
		req_vec[tlip_pkg::BIT_EXT_D]       = src_req.ext_pin_source_d;
		req_vec[tlip_pkg::BIT_RADIO_RX]    = src_req.radio_receive_source;
		req_vec[tlip_pkg::BIT_RADIO_TX]    = src_req.radio_transmit_source;
		req_vec[tlip_pkg::BIT_RADIO_TIMER] = src_req.radio_timer_source;
		req_vec[tlip_pkg::BIT_ADC]         = src_req.adc_source;
		req_vec[tlip_pkg::BIT_SECURITY]    = src_req.security_source;
		req_vec[tlip_pkg::BIT_SERIAL_TWO]  = src_req.serial_ctrl_two_source;
		req_vec[tlip_pkg::BIT_SERIAL_ONE]  = src_req.serial_ctrl_one_source;
		req_vec[tlip_pkg::BIT_SLEEP_TIMER] = src_req.sleep_timer_source;
		req_vec[tlip_pkg::BIT_BASEBAND]    = src_req.baseband_source;
		req_vec[tlip_pkg::BIT_MANAGEMENT]  = src_req.management_source;
		req_vec[tlip_pkg::BIT_TIMER_TWO]   = src_req.timer_two_source;
		req_vec[tlip_pkg::BIT_TIMER_ONE]   = src_req.timer_one_source;
	end

	////////////////////////////////////////////////////////////////////////
	// write decode, byte lanes gate the ones
	assign lane_mask = {{8{wr.strb[3]}}, {8{wr.strb[2]}},
	                    {8{wr.strb[1]}}, {8{wr.strb[0]}}};

	always_comb begin
		set_vec    = tlip_pkg::RST_SRC_VEC;
		clr_vec    = tlip_pkg::RST_SRC_VEC;
		st_clr_vec = tlip_pkg::RST_SRC_VEC;
		mask_nxt   = mask_r;
		wr_hit     = 1'b0;
		if (wr_en) begin
			unique case (wr.addr)
				tlip_pkg::OFS_PENDING_SET: begin
					set_vec = wr.data[16:0] & lane_mask[16:0];
					wr_hit  = 1'b1;
				end
				tlip_pkg::OFS_PENDING_CLEAR: begin
					clr_vec = wr.data[16:0] & lane_mask[16:0];
					wr_hit  = 1'b1;
				end
				tlip_pkg::OFS_ACTIVE: begin
					wr_hit = 1'b1;
				end
				tlip_pkg::OFS_EVENT_STATUS: begin
					st_clr_vec = wr.data[16:0] & lane_mask[16:0];
					wr_hit     = 1'b1;
				end
				tlip_pkg::OFS_EVENT_MASK: begin
					mask_nxt = (mask_r & ~lane_mask[16:0]) |
					           (wr.data[16:0] & lane_mask[16:0]);
					wr_hit   = 1'b1;
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one cell per source
	genvar gi;
	generate
		for (gi = 0; gi < tlip_pkg::NSRC; gi++) begin : g_src
			tlip_src_cell u_cell (
				.clk       (clk),
				.nrst      (nrst),
				.req       (req_vec[gi]),
				.sw_set    (set_vec[gi]),
				.sw_clr    (clr_vec[gi]),
				.enter     (handler_enter[gi]),
				.leave     (handler_exit[gi]),
				.pend      (pend_vec[gi]),
				.act       (act_vec[gi]),
				.pend_rise (rise_vec[gi])
			);
		end
	endgenerate

	assign pending_state = pend_vec;
	assign active_state  = act_vec;

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		rd_data = tlip_pkg::RST_RDATA;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			tlip_pkg::OFS_PENDING_SET,
			tlip_pkg::OFS_PENDING_CLEAR: begin
				rd_data = {tlip_pkg::ZERO_UPPER, pend_vec};
			end
			tlip_pkg::OFS_ACTIVE: begin
				rd_data = {tlip_pkg::ZERO_UPPER, act_vec};
			end
			tlip_pkg::OFS_EVENT_STATUS: begin
				rd_data = {tlip_pkg::ZERO_UPPER, status_r};
			end
			tlip_pkg::OFS_EVENT_MASK: begin
				rd_data = {tlip_pkg::ZERO_UPPER, mask_r};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// event status, mask and interrupt line
	always_comb begin
		status_nxt = (status_r & ~st_clr_vec) | rise_vec;
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= tlip_pkg::RST_SRC_VEC;
			mask_r   <= tlip_pkg::RST_SRC_VEC;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence seq_set_write;
		wr_en && wr.addr == tlip_pkg::OFS_PENDING_SET && set_vec != '0;
	endsequence

	sequence seq_clr_write;
		wr_en && wr.addr == tlip_pkg::OFS_PENDING_CLEAR && clr_vec != '0;
	endsequence

	chk_set_write_pends: assert property (
		@(posedge clk) disable iff (!nrst)
		seq_set_write |=> (pend_vec & $past(set_vec)) == $past(set_vec))
		else $error("set write missed a source");

	chk_clr_write_unpends: assert property (
		@(posedge clk) disable iff (!nrst)
		seq_clr_write ##0 (set_vec == '0 && req_vec == '0)
		|=> (pend_vec & $past(clr_vec)) == '0)
		else $error("clear write left a source pending");

	chk_map_ext_a: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.ext_pin_source_a |=> pending_state[12])
		else $error("pin source a not on bit 12");

	chk_map_radio_rx: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.radio_receive_source |=> pending_state[10])
		else $error("radio receive not on bit 10");

	chk_map_security: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.security_source |=> pending_state[7])
		else $error("security not on bit 7");

	chk_map_serial_two: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.serial_ctrl_two_source |=> pending_state[6])
		else $error("serial two not on bit 6");

	chk_map_baseband: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.baseband_source |=> pending_state[3])
		else $error("baseband not on bit 3");

	chk_map_timer_two: assert property (
		@(posedge clk) disable iff (!nrst)
		src_req.timer_two_source |=> pending_state[1])
		else $error("timer two not on bit 1");

	chk_read_pending: assert property (
		@(posedge clk) disable iff (!nrst)
		ar_take && (s_axi_araddr == tlip_pkg::OFS_PENDING_CLEAR)
		|=> s_axi_rvalid && s_axi_rdata == {15'h0000, $past(pend_vec)})
		else $error("pending read wrong");

	chk_read_active: assert property (
		@(posedge clk) disable iff (!nrst)
		ar_take && (s_axi_araddr == tlip_pkg::OFS_ACTIVE)
		|=> s_axi_rdata == {15'h0000, $past(act_vec)})
		else $error("active read wrong");

	chk_irq_level: assert property (
		@(posedge clk) disable iff (!nrst)
		(|(status_r & mask_r)) && !wr_en |=> irq)
		else $error("interrupt line low with unmasked status");

endmodule

// file: pkg/tlip_pkg.sv
package tlip_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NSRC   = 17;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	////////////////////////////////////////////////////////////////////////
	// source bit positions
	localparam int BIT_TIMER_ONE    = 0;
	localparam int BIT_TIMER_TWO    = 1;
	localparam int BIT_MANAGEMENT   = 2;
	localparam int BIT_BASEBAND     = 3;
	localparam int BIT_SLEEP_TIMER  = 4;
	localparam int BIT_SERIAL_ONE   = 5;
	localparam int BIT_SERIAL_TWO   = 6;
	localparam int BIT_SECURITY     = 7;
	localparam int BIT_RADIO_TIMER  = 8;
	localparam int BIT_RADIO_TX     = 9;
	localparam int BIT_RADIO_RX     = 10;
	localparam int BIT_ADC          = 11;
	localparam int BIT_EXT_A        = 12;
	localparam int BIT_EXT_B        = 13;
	localparam int BIT_EXT_C        = 14;
	localparam int BIT_EXT_D        = 15;
	localparam int BIT_DEBUG        = 16;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [31:0] OFS_PENDING_SET   = 32'he000_e200;
	localparam logic [31:0] OFS_PENDING_CLEAR = 32'he000_e280;
	localparam logic [31:0] OFS_ACTIVE        = 32'he000_e300;
	localparam logic [31:0] OFS_EVENT_STATUS  = 32'he000_e380;
	localparam logic [31:0] OFS_EVENT_MASK    = 32'he000_e384;

	////////////////////////////////////////////////////////////////////////
	// reset values and responses
	localparam logic [16:0] RST_SRC_VEC  = 17'h0_0000;
	localparam logic        RST_SRC_BIT  = 1'h0;
	localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
	localparam logic [14:0] ZERO_UPPER   = 15'h0000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef logic [NSRC-1:0] tlip_src_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} tlip_wr_s;

	typedef struct packed {
		logic debug_source;
		logic ext_pin_source_d;
		logic ext_pin_source_c;
		logic ext_pin_source_b;
		logic ext_pin_source_a;
		logic adc_source;
		logic radio_receive_source;
		logic radio_transmit_source;
		logic radio_timer_source;
		logic security_source;
		logic serial_ctrl_two_source;
		logic serial_ctrl_one_source;
		logic sleep_timer_source;
		logic baseband_source;
		logic management_source;
		logic timer_two_source;
		logic timer_one_source;
	} tlip_req_s;

endpackage

// file: rtl/tlip_src_cell.sv
`timescale 1ns/10ps
module tlip_src_cell (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic req,
	input  wire logic sw_set,
	input  wire logic sw_clr,
	input  wire logic enter,
	input  wire logic leave,
	output logic      pend,
	output logic      act,
	output logic      pend_rise
);

	logic pend_r;
	logic pend_nxt;
	logic act_r;
	logic act_nxt;

	////////////////////////////////////////////////////////////////////////
	// pending and active state, set wins over clear
	always_comb begin
		pend_nxt = pend_r;
		act_nxt  = act_r;
		if (sw_clr || enter) begin
			pend_nxt = 1'b0;
		end
		if (sw_set || req) begin
			pend_nxt = 1'b1;
		end
		if (leave) begin
			act_nxt = 1'b0;
		end
		if (enter) begin
			act_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_r <= tlip_pkg::RST_SRC_BIT;
			act_r  <= tlip_pkg::RST_SRC_BIT;
		end else begin
			pend_r <= pend_nxt;
			act_r  <= act_nxt;
		end
	end

	assign pend      = pend_r;
	assign act       = act_r;
	assign pend_rise = pend_nxt & ~pend_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_set_pends: assert property (
		@(posedge clk) disable iff (!nrst)
		sw_set |=> pend_r)
		else $error("set write did not pend source");

	chk_zero_set_keeps: assert property (
		@(posedge clk) disable iff (!nrst)
		!pend_r && !sw_set && !req |=> !pend_r)
		else $error("pending rose without a set");

	chk_clr_unpends: assert property (
		@(posedge clk) disable iff (!nrst)
		sw_clr && !sw_set && !req |=> !pend_r)
		else $error("clear write did not unpend source");

	chk_zero_clr_keeps: assert property (
		@(posedge clk) disable iff (!nrst)
		pend_r && !sw_clr && !enter |=> pend_r)
		else $error("pending fell without a clear");

	chk_req_holds: assert property (
		@(posedge clk) disable iff (!nrst)
		req [*2] |-> pend_r)
		else $error("held request not pending");

	chk_enter_moves: assert property (
		@(posedge clk) disable iff (!nrst)
		enter && !req && !sw_set |=> !pend_r && act_r)
		else $error("handler entry did not move to active");

	chk_leave_clears: assert property (
		@(posedge clk) disable iff (!nrst)
		leave && !enter |=> !act_r)
		else $error("handler exit left source active");

endmodule

// file: rtl/tlip_axil_slave.sv
`timescale 1ns/10ps
module tlip_axil_slave (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic                      wr_en,
	output tlip_pkg::tlip_wr_s        wr,
	input  wire logic                 wr_hit,
	input  wire logic [31:0]          rd_data,
	input  wire logic                 rd_hit
);

	logic               aw_held_r, aw_held_nxt;
	logic               w_held_r, w_held_nxt;
	tlip_pkg::tlip_wr_s wr_r, wr_nxt;
	logic               awready_r, awready_nxt;
	logic               wready_r, wready_nxt;
	logic               bvalid_r, bvalid_nxt;
	logic [1:0]         bresp_r, bresp_nxt;
	logic               arready_r, arready_nxt;
	logic               rvalid_r, rvalid_nxt;
	logic [31:0]        rdata_r, rdata_nxt;
	logic [1:0]         rresp_r, rresp_nxt;

	////////////////////////////////////////////////////////////////////////
	// write path: address and data in either order
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		wr_nxt      = wr_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && awready_r) begin
			aw_held_nxt = 1'b1;
			wr_nxt.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_held_nxt  = 1'b1;
			wr_nxt.data = s_axi_wdata;
			wr_nxt.strb = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_held_r && w_held_r) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? tlip_pkg::RESP_OKAY
			                     : tlip_pkg::RESP_SLVERR;
		end
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt  = !w_held_nxt && !bvalid_nxt;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			wr_r      <= '0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= tlip_pkg::RESP_OKAY;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			wr_r      <= wr_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: data captured at the address handshake
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_hit ? rd_data : tlip_pkg::RST_RDATA;
			rresp_nxt  = rd_hit ? tlip_pkg::RESP_OKAY
			                    : tlip_pkg::RESP_SLVERR;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= tlip_pkg::RST_RDATA;
			rresp_r   <= tlip_pkg::RESP_OKAY;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	assign wr_en         = aw_held_r && w_held_r;
	assign wr            = wr_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

endmodule

// file: verif/tlip_peer.sv
`timescale 1ns/10ps
module tlip_peer (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire tlip_pkg::tlip_src_t want_req,
	input  wire tlip_pkg::tlip_src_t want_enter,
	input  wire tlip_pkg::tlip_src_t want_exit,
	output tlip_pkg::tlip_req_s      src_req,
	output tlip_pkg::tlip_src_t      handler_enter,
	output tlip_pkg::tlip_src_t      handler_exit
);
	tlip_pkg::tlip_src_t ent_r;
	tlip_pkg::tlip_src_t ext_r;
	////////////////////////////////////////////////////////////////////////
	// request levels and one-cycle core pulses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_req       <= '0;
			handler_enter <= '0;
			handler_exit  <= '0;
			ent_r         <= '0;
			ext_r         <= '0;
		end else begin
			src_req       <= want_req;
			handler_enter <= want_enter & ~ent_r;
			handler_exit  <= want_exit & ~ext_r;
			ent_r         <= want_enter;
			ext_r         <= want_exit;
		end
	end
endmodule

// file: verif/top_level_interrupt_pending_test.sv
`timescale 1ns/10ps
module top_level_interrupt_pending_test;
	typedef struct packed {
		logic [31:0] wa;
		logic [31:0] wd;
		logic [31:0] ra;
		logic [31:0] ex;
	} tlip_row_s;
	localparam logic [31:0] PS = tlip_pkg::OFS_PENDING_SET;
	localparam logic [31:0] PC = tlip_pkg::OFS_PENDING_CLEAR;
	localparam logic [31:0] AC = tlip_pkg::OFS_ACTIVE;
	localparam logic [31:0] ST = tlip_pkg::OFS_EVENT_STATUS;
	localparam logic [31:0] MK = tlip_pkg::OFS_EVENT_MASK;
	localparam logic [31:0] F1 = 32'hffff_ffff;
	localparam logic [31:0] Z0 = 32'h0000_0000;
	tlip_row_s rows [8] = '{
		'{PS, Z0, PS, Z0},
		'{PS, 32'h0001_0000, PS, 32'h0001_0000},
		'{PS, Z0, PC, 32'h0001_0000},
		'{PC, Z0, PS, 32'h0001_0000},
		'{PC, 32'h0001_0000, PS, Z0},
		'{PS, F1, PC, 32'h0001_ffff},
		'{PC, 32'h0000_f000, PS, 32'h0001_0fff},
		'{PC, F1, PS, Z0}};
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	logic [31:0]         s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0]          s_axi_wstrb = '0;
	logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                s_axi_arvalid = 1'b0;
	logic                s_axi_bready = 1'b0, s_axi_rready = 1'b0;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]          s_axi_bresp, s_axi_rresp, r;
	logic [31:0]         s_axi_rdata, d;
	tlip_pkg::tlip_src_t want_req = '0, want_enter = '0, want_exit = '0;
	tlip_pkg::tlip_src_t handler_enter, handler_exit;
	tlip_pkg::tlip_src_t pending_state, active_state;
	tlip_pkg::tlip_req_s src_req;
	int                  failures = 0;
	int                  checks = 0;

	always #50 clk = ~clk;

	tlip_top uut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .src_req, .handler_enter,
		.handler_exit, .pending_state, .active_state, .irq);
	tlip_peer peer (.clk, .nrst, .want_req, .want_enter, .want_exit,
		.src_req, .handler_enter, .handler_exit);

	////////////////////////////////////////////////////////////////////////
	// verdict, compares, bounded waits
	task automatic conclude();
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic guard(input int n);
		if (n > 40) begin
			failures++;
			conclude();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// axi4-lite master
	task automatic wr(input logic [31:0] a, input logic [31:0] v,
		output logic [1:0] rsp);
		int n;
		bit ga;
		bit gw;
		n = 0;
		ga = 0;
		gw = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ga && gw)) begin
			@(negedge clk);
			ga = ga | (s_axi_awvalid & s_axi_awready);
			gw = gw | (s_axi_wvalid & s_axi_wready);
			@(posedge clk);
			if (ga)
				s_axi_awvalid <= 1'b0;
			if (gw)
				s_axi_wvalid <= 1'b0;
			guard(n++);
		end
		do begin
			@(negedge clk);
			guard(n++);
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v,
		output logic [1:0] rsp);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			guard(n++);
		end while ((s_axi_arvalid & s_axi_arready) !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge clk);
			guard(n++);
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rmap(input tlip_pkg::tlip_req_s q, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rsp;
		@(posedge clk);
		want_req <= q;
		repeat (3) @(posedge clk);
		rd(PS, v, rsp);
		cmp_data(v, e);
		want_req <= '0;
		wr(PC, F1, rsp);
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		cmp_data({15'h0000, pending_state}, Z0);
		cmp_data({14'h0000, active_state, irq}, Z0);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd, r);
			cmp_resp(r, tlip_pkg::RESP_OKAY);
			rd(rows[i].ra, d, r);
			cmp_data(d, rows[i].ex);
		end
		rmap('{ext_pin_source_a: 1'b1, default: '0}, 32'h0000_1000);
		rmap('{ext_pin_source_d: 1'b1, default: '0}, 32'h0000_8000);
		rmap('{radio_receive_source: 1'b1, default: '0}, 32'h0000_0400);
		rmap('{radio_timer_source: 1'b1, default: '0}, 32'h0000_0100);
		rmap('{adc_source: 1'b1, default: '0}, 32'h0000_0800);
		rmap('{security_source: 1'b1, default: '0}, 32'h0000_0080);
		rmap('{serial_ctrl_two_source: 1'b1, default: '0}, 32'h0000_0040);
		rmap('{serial_ctrl_one_source: 1'b1, default: '0}, 32'h0000_0020);
		rmap('{sleep_timer_source: 1'b1, default: '0}, 32'h0000_0010);
		rmap('{management_source: 1'b1, default: '0}, 32'h0000_0004);
		rmap('{timer_two_source: 1'b1, default: '0}, 32'h0000_0002);
		rmap('{timer_one_source: 1'b1, default: '0}, 32'h0000_0001);
		// held request beats clear, then stays pending
		want_req <= 17'h0_0008;
		wr(PC, F1, r);
		rd(PS, d, r);
		cmp_data(d, 32'h0000_0008);
		want_req <= '0;
		wr(PC, Z0, r);
		rd(PC, d, r);
		cmp_data(d, 32'h0000_0008);
		want_enter <= 17'h0_0008;
		wr(AC, F1, r);
		cmp_resp(r, tlip_pkg::RESP_OKAY);
		rd(AC, d, r);
		cmp_data(d, 32'h0000_0008);
		rd(PS, d, r);
		cmp_data(d, Z0);
		want_enter <= '0;
		want_exit <= 17'h0_0008;
		repeat (2) @(posedge clk);
		rd(AC, d, r);
		cmp_data(d, Z0);
		want_exit <= '0;
		// event status, mask and interrupt line
		wr(ST, F1, r);
		wr(MK, Z0, r);
		wr(PS, 32'h0000_0004, r);
		rd(ST, d, r);
		cmp_data(d, 32'h0000_0004);
		cmp_data({31'h0000_0000, irq}, Z0);
		wr(MK, 32'h0000_0004, r);
		cmp_data({31'h0000_0000, irq}, 32'h0000_0001);
		wr(ST, 32'h0000_0004, r);
		cmp_data({31'h0000_0000, irq}, Z0);
		// unmapped place
		wr(32'he000_e204, F1, r);
		cmp_resp(r, tlip_pkg::RESP_SLVERR);
		rd(32'he000_e204, d, r);
		cmp_resp(r, tlip_pkg::RESP_SLVERR);
		cmp_data(d, Z0);
		// second reset clears pending
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(PS, d, r);
		cmp_data(d, Z0);
		conclude();
	end
endmodule
